// ---- core/ppf_pkg.sv ----
// Constants for the port 0 pin function select block (pins 5, 6 and 7).
package ppf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry of the block.
  localparam int PIN_COUNT = 3;
  localparam int ADDR_WIDTH = 32;
  localparam int DATA_WIDTH = 16;
  localparam int SEL_WIDTH = 5;
  localparam int PULL_WIDTH = 2;
  localparam int CODE_COUNT = 32;
  localparam int IN_COUNT = 11;

  // Port 0 index of each pin served, lowest index first.
  localparam logic [3:0] PIN_INDEX [PIN_COUNT] = '{4'h5, 4'h6, 4'h7};
  // Highest port 0 index on which analogue and diagnostic routing exist.
  localparam logic [3:0] ANALOG_MAX_INDEX = 4'h3;
  localparam logic [3:0] DIAG_MAX_INDEX = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [31:0] PIN5_MODE_SELECT_ADDR = 32'h50003010;
  localparam logic [31:0] PIN6_MODE_SELECT_ADDR = 32'h50003012;
  localparam logic [31:0] PIN7_MODE_SELECT_ADDR = 32'h50003014;
  localparam logic [31:0] MODE_ADDR [PIN_COUNT] =
    '{PIN5_MODE_SELECT_ADDR, PIN6_MODE_SELECT_ADDR, PIN7_MODE_SELECT_ADDR};

  // Field layout of a mode register.
  localparam int PULL_LSB = 8;
  localparam int PULL_MSB = 9;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 4;

  // Reset values.
  localparam logic [1:0] PULL_RESET = 2'h2;
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Pull and direction encodings.
  localparam logic [1:0] PULL_NONE_IN = 2'h0;
  localparam logic [1:0] PULL_UP_IN = 2'h1;
  localparam logic [1:0] PULL_DOWN_IN = 2'h2;
  localparam logic [1:0] PULL_OUTPUT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Function selector codes.
  localparam logic [4:0] FN_PORT = 5'h00;
  localparam logic [4:0] FN_SA_RX = 5'h01;
  localparam logic [4:0] FN_SA_TX = 5'h02;
  localparam logic [4:0] FN_SB_RX = 5'h03;
  localparam logic [4:0] FN_SB_TX = 5'h04;
  localparam logic [4:0] FN_SPI_DIN = 5'h05;
  localparam logic [4:0] FN_SPI_DO = 5'h06;
  localparam logic [4:0] FN_SPI_CLK = 5'h07;
  localparam logic [4:0] FN_SPI_EN = 5'h08;
  localparam logic [4:0] FN_I2C_SCL = 5'h09;
  localparam logic [4:0] FN_I2C_SDA = 5'h0A;
  localparam logic [4:0] FN_SA_IR_RX = 5'h0B;
  localparam logic [4:0] FN_SA_IR_TX = 5'h0C;
  localparam logic [4:0] FN_SB_IR_RX = 5'h0D;
  localparam logic [4:0] FN_SB_IR_TX = 5'h0E;
  localparam logic [4:0] FN_ANALOG = 5'h0F;
  localparam logic [4:0] FN_PULSE0 = 5'h10;
  localparam logic [4:0] FN_PULSE1 = 5'h11;
  localparam logic [4:0] FN_DIAG = 5'h12;
  localparam logic [4:0] FN_SA_CTS = 5'h13;
  localparam logic [4:0] FN_SA_RTS = 5'h14;
  localparam logic [4:0] FN_SB_CTS = 5'h15;
  localparam logic [4:0] FN_SB_RTS = 5'h16;
  localparam logic [4:0] FN_PULSE2 = 5'h17;
  localparam logic [4:0] FN_PULSE3 = 5'h18;
  localparam logic [4:0] FN_PULSE4 = 5'h19;
  localparam logic [4:0] FN_LAST = 5'h19;

  // Peripheral input slots, and the selector code that feeds each.
  localparam logic [4:0] IN_CODE [IN_COUNT] = '{
    FN_SA_RX, FN_SB_RX, FN_SPI_DIN, FN_SPI_CLK, FN_SPI_EN, FN_I2C_SCL,
    FN_I2C_SDA, FN_SA_IR_RX, FN_SB_IR_RX, FN_SA_CTS, FN_SB_CTS};

endpackage

// ---- core/ppf_pin_function_select.sv ----
// Pin mode registers and function routing for port 0 pins 5, 6 and 7.
//
// Overview of operation
// - Pull field 00 none, 01 up, 10 down, 11 output.
// - Pull field resets to 10, pulled-down input.
// - Analogue routing ignores the pull field.
// - Selector 0 is port function, resets to zero.
// - Codes 1-4 are serial A and B lines.
// - Codes 5-8 SPI lines, 9-10 I2C lines.
// - Codes 11-14 are serial A and B infrared.
// - Code 15 analogue, only on port 0 pins 3-0.
// - Code 18 radio diagnostic, port 0 pins 7-0.
// - Codes 19-22 are serial A and B flow control.
// - Codes 16, 17, 23-25 are pulse outputs 0-4.
// - Input conflict: lowest selecting pin index wins.
// - Port 0 pins beat every port 1 pin.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module ppf_pin_function_select
  import ppf_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port.
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [DATA_WIDTH-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_WIDTH-1:0] reg_rdata,
  // Pads.
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pad_pull_up,
  output logic [PIN_COUNT-1:0] pad_pull_down,
  output logic [PIN_COUNT-1:0] pad_analog,
  // Plain port function.
  input wire logic [PIN_COUNT-1:0] port_out,
  output logic [PIN_COUNT-1:0] port_in,
  // Peripheral outputs towards the pins.
  input wire logic serial_a_transmit,
  input wire logic serial_b_transmit,
  input wire logic serial_a_infrared_transmit,
  input wire logic serial_b_infrared_transmit,
  input wire logic serial_a_request_to_send,
  input wire logic serial_b_request_to_send,
  input wire logic spi_data_out,
  input wire logic spi_clk_out,
  input wire logic spi_clk_oe,
  input wire logic spi_en_out,
  input wire logic spi_en_oe,
  input wire logic i2c_scl_drive_low,
  input wire logic i2c_sda_drive_low,
  input wire logic pulse_out_zero,
  input wire logic pulse_out_one,
  input wire logic pulse_out_two,
  input wire logic pulse_out_three,
  input wire logic pulse_out_four,
  input wire logic radio_diagnostic_out,
  // Peripheral inputs from the pins.
  output logic serial_a_receive,
  output logic serial_b_receive,
  output logic spi_data_in_sel,
  output logic spi_clk_in,
  output logic spi_en_in,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic serial_a_infrared_receive,
  output logic serial_b_infrared_receive,
  output logic serial_a_clear_to_send,
  output logic serial_b_clear_to_send,
  // Priority chain with port 0 pins 0-4 above and port 1 below.
  input wire logic [IN_COUNT-1:0] lower_claim,
  input wire logic [IN_COUNT-1:0] lower_value,
  input wire logic [IN_COUNT-1:0] port1_value,
  output logic [IN_COUNT-1:0] port0_claim
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Codes outside the table, and codes a pin cannot honour, fall back to port.
  function automatic logic [4:0] effective_sel(input logic [4:0] sel, input logic [3:0] idx);
    logic [4:0] result;
    result = sel;
    if (sel > FN_LAST) begin
      result = FN_PORT;
    end
    if (sel == FN_ANALOG && idx > ANALOG_MAX_INDEX) begin
      result = FN_PORT;
    end
    if (sel == FN_DIAG && idx > DIAG_MAX_INDEX) begin
      result = FN_PORT;
    end
    return result;
  endfunction

  function automatic logic [DATA_WIDTH-1:0] pack_mode(input logic [1:0] pull,
                                                      input logic [4:0] sel);
    logic [DATA_WIDTH-1:0] word;
    word = READ_IDLE;
    word[PULL_MSB:PULL_LSB] = pull;
    word[SEL_MSB:SEL_LSB] = sel;
    return word;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers.

  logic [1:0] pull_direction_field_reg [PIN_COUNT];
  logic [4:0] function_selector_reg [PIN_COUNT];
  logic [DATA_WIDTH-1:0] reg_rdata_reg;
  logic [DATA_WIDTH-1:0] reg_rdata_next;
  logic [PIN_COUNT-1:0] addr_hit;
  logic [PIN_COUNT-1:0] write_hit;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_regs
      assign addr_hit[g] = (reg_addr == MODE_ADDR[g]);
      assign write_hit[g] = reg_write && addr_hit[g];

      // Only the two fields are stored, so reserved bits drop on write.
      always_ff @(posedge clk) begin
        if (rst) begin
          pull_direction_field_reg[g] <= PULL_RESET;
          function_selector_reg[g] <= SEL_RESET;
        end else if (ce && write_hit[g]) begin
          pull_direction_field_reg[g] <= reg_wdata[PULL_MSB:PULL_LSB];
          function_selector_reg[g] <= reg_wdata[SEL_MSB:SEL_LSB];
        end
      end
    end
  endgenerate

  // Unmapped reads return zero.
  always_comb begin
    reg_rdata_next = READ_IDLE;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (addr_hit[i]) begin
        reg_rdata_next = pack_mode(pull_direction_field_reg[i], function_selector_reg[i]);
      end
    end
  end

  // Read data stand for one cycle only, then return to zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_reg <= READ_IDLE;
    end else if (ce) begin
      reg_rdata_reg <= reg_read ? reg_rdata_next : READ_IDLE;
    end
  end
  assign reg_rdata = reg_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Output table: value and enable that each code puts on a pin.

  logic [CODE_COUNT-1:0] code_out;
  logic [CODE_COUNT-1:0] code_oe;

  always_comb begin
    code_out = '0;
    code_oe = '0;
    code_out[FN_SA_TX] = serial_a_transmit;
    code_oe[FN_SA_TX] = 1'b1;
    code_out[FN_SB_TX] = serial_b_transmit;
    code_oe[FN_SB_TX] = 1'b1;
    code_out[FN_SPI_DO] = spi_data_out;
    code_oe[FN_SPI_DO] = 1'b1;
    code_out[FN_SPI_CLK] = spi_clk_out;
    code_oe[FN_SPI_CLK] = spi_clk_oe;
    code_out[FN_SPI_EN] = spi_en_out;
    code_oe[FN_SPI_EN] = spi_en_oe;
    code_oe[FN_I2C_SCL] = i2c_scl_drive_low;
    code_oe[FN_I2C_SDA] = i2c_sda_drive_low;
    code_out[FN_SA_IR_TX] = serial_a_infrared_transmit;
    code_oe[FN_SA_IR_TX] = 1'b1;
    code_out[FN_SB_IR_TX] = serial_b_infrared_transmit;
    code_oe[FN_SB_IR_TX] = 1'b1;
    code_out[FN_PULSE0] = pulse_out_zero;
    code_oe[FN_PULSE0] = 1'b1;
    code_out[FN_PULSE1] = pulse_out_one;
    code_oe[FN_PULSE1] = 1'b1;
    code_out[FN_PULSE2] = pulse_out_two;
    code_oe[FN_PULSE2] = 1'b1;
    code_out[FN_PULSE3] = pulse_out_three;
    code_oe[FN_PULSE3] = 1'b1;
    code_out[FN_PULSE4] = pulse_out_four;
    code_oe[FN_PULSE4] = 1'b1;
    code_out[FN_DIAG] = radio_diagnostic_out;
    code_oe[FN_DIAG] = 1'b1;
    code_out[FN_SA_RTS] = serial_a_request_to_send;
    code_oe[FN_SA_RTS] = 1'b1;
    code_out[FN_SB_RTS] = serial_b_request_to_send;
    code_oe[FN_SB_RTS] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin routing.

  logic [4:0] sel_eff [PIN_COUNT];
  logic [PIN_COUNT-1:0] is_port;
  logic [PIN_COUNT-1:0] is_analog;
  logic [PIN_COUNT-1:0] pad_out_next;
  logic [PIN_COUNT-1:0] pad_oe_next;
  logic [PIN_COUNT-1:0] pull_up_next;
  logic [PIN_COUNT-1:0] pull_down_next;
  logic [PIN_COUNT-1:0] pad_out_reg;
  logic [PIN_COUNT-1:0] pad_oe_reg;
  logic [PIN_COUNT-1:0] pull_up_reg;
  logic [PIN_COUNT-1:0] pull_down_reg;
  logic [PIN_COUNT-1:0] analog_reg;
  logic [PIN_COUNT-1:0] port_in_reg;

  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pins
      assign sel_eff[g] = effective_sel(function_selector_reg[g], PIN_INDEX[g]);
      assign is_port[g] = (sel_eff[g] == FN_PORT);
      assign is_analog[g] = (sel_eff[g] == FN_ANALOG);
      // In port function the pull field also sets the direction.
      assign pad_out_next[g] = is_port[g] ? port_out[g] : code_out[sel_eff[g]];
      assign pad_oe_next[g] = is_port[g] ?
        (pull_direction_field_reg[g] == PULL_OUTPUT) : code_oe[sel_eff[g]];
      // Analogue routing drops pulls whatever the field holds.
      assign pull_up_next[g] = !is_analog[g] &&
        (pull_direction_field_reg[g] == PULL_UP_IN);
      assign pull_down_next[g] = !is_analog[g] &&
        (pull_direction_field_reg[g] == PULL_DOWN_IN);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out_reg <= '0;
    end else if (ce) begin
      pad_out_reg <= pad_out_next;
    end
  end

  // Pads come up undriven so nothing fights an external source at power-up.
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_oe_reg <= '0;
    end else if (ce) begin
      pad_oe_reg <= pad_oe_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pull_up_reg <= '0;
    end else if (ce) begin
      pull_up_reg <= pull_up_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pull_down_reg <= '1;
    end else if (ce) begin
      pull_down_reg <= pull_down_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      analog_reg <= '0;
    end else if (ce) begin
      analog_reg <= is_analog;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_in_reg <= '0;
    end else if (ce) begin
      port_in_reg <= pad_in;
    end
  end

  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign pad_pull_up = pull_up_reg;
  assign pad_pull_down = pull_down_reg;
  assign pad_analog = analog_reg;
  assign port_in = port_in_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral inputs with priority.

  logic [IN_COUNT-1:0] local_claim;
  logic [IN_COUNT-1:0] local_value;
  logic [IN_COUNT-1:0] in_next;
  logic [IN_COUNT-1:0] in_reg;
  logic [IN_COUNT-1:0] claim_reg;

  // Scanning from the highest pin down lets the lowest selecting pin win.
  always_comb begin
    local_claim = '0;
    local_value = '0;
    for (int s = 0; s < IN_COUNT; s++) begin
      for (int p = PIN_COUNT - 1; p >= 0; p--) begin
        if (sel_eff[p] == IN_CODE[s]) begin
          local_claim[s] = 1'b1;
          local_value[s] = pad_in[p];
        end
      end
    end
  end

  // Pins 0-4 outrank ours; any port 0 pin outranks every port 1 pin.
  assign in_next = (lower_claim & lower_value) |
    (~lower_claim & local_claim & local_value) |
    (~lower_claim & ~local_claim & port1_value);

  always_ff @(posedge clk) begin
    if (rst) begin
      in_reg <= '0;
    end else if (ce) begin
      in_reg <= in_next;
    end
  end

  // The claim goes on to port 1 so that its own pins give way.
  always_ff @(posedge clk) begin
    if (rst) begin
      claim_reg <= '0;
    end else if (ce) begin
      claim_reg <= lower_claim | local_claim;
    end
  end

  assign port0_claim = claim_reg;
  assign serial_a_receive = in_reg[0];
  assign serial_b_receive = in_reg[1];
  assign spi_data_in_sel = in_reg[2];
  assign spi_clk_in = in_reg[3];
  assign spi_en_in = in_reg[4];
  assign i2c_scl_in = in_reg[5];
  assign i2c_sda_in = in_reg[6];
  assign serial_a_infrared_receive = in_reg[7];
  assign serial_b_infrared_receive = in_reg[8];
  assign serial_a_clear_to_send = in_reg[9];
  assign serial_b_clear_to_send = in_reg[10];

endmodule

// ---- tb/ppf_pin_function_select_checker.sv ----
// Concurrent checks on the ports of the pin function select block.
`timescale 1ns/10ps
module ppf_pin_function_select_checker
  import ppf_pkg::*;
(
  // Clock and control.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port.
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [DATA_WIDTH-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_WIDTH-1:0] reg_rdata,
  // Pads.
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  input wire logic [PIN_COUNT-1:0] pad_pull_up,
  input wire logic [PIN_COUNT-1:0] pad_pull_down,
  input wire logic [PIN_COUNT-1:0] pad_analog,
  // Sources and peripheral inputs.
  input wire logic [PIN_COUNT-1:0] port_out,
  input wire logic serial_a_transmit,
  input wire logic pulse_out_four,
  input wire logic radio_diagnostic_out,
  input wire logic i2c_scl_drive_low,
  input wire logic serial_a_receive,
  input wire logic [IN_COUNT-1:0] lower_claim,
  input wire logic [IN_COUNT-1:0] lower_value,
  input wire logic [IN_COUNT-1:0] port0_claim
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A write lands in the register at its edge; the pads follow one edge later.
  wire w5 = ce && reg_write && reg_addr == PIN5_MODE_SELECT_ADDR;
  wire w6 = ce && reg_write && reg_addr == PIN6_MODE_SELECT_ADDR;
  wire w7 = ce && reg_write && reg_addr == PIN7_MODE_SELECT_ADDR;
  wire [4:0] wsel = reg_wdata[4:0];
  wire [1:0] wpull = reg_wdata[9:8];
  AST_RESET_PADS: assert property ($past(rst) && $past(ce) |->
    pad_pull_down == 3'h7 && pad_pull_up == 3'h0 && pad_oe == 3'h0) else $error("reset pads");
  AST_RDATA_IDLE: assert property ($past(ce) && !$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  AST_PORT_PULL: assert property (w5 && wsel == FN_PORT |-> ##2
    pad_oe[0] == ($past(wpull, 2) == PULL_OUTPUT) && pad_pull_up[0] == ($past(wpull, 2) ==
    PULL_UP_IN) && pad_pull_down[0] == ($past(wpull, 2) == PULL_DOWN_IN)) else $error("pull");
  AST_SERIAL_TX: assert property (w5 && wsel == FN_SA_TX |-> ##2
    pad_oe[0] && pad_out[0] == $past(serial_a_transmit)) else $error("serial tx");
  AST_SCL_DRAIN: assert property (w7 && wsel == FN_I2C_SCL |-> ##2
    !pad_out[2] && pad_oe[2] == $past(i2c_scl_drive_low)) else $error("scl drain");
  AST_DIAG_OUT: assert property (w6 && wsel == FN_DIAG |-> ##2
    pad_oe[1] && pad_out[1] == $past(radio_diagnostic_out)) else $error("diag");
  AST_PULSE_FOUR: assert property (w7 && wsel == FN_PULSE4 |-> ##2
    pad_oe[2] && pad_out[2] == $past(pulse_out_four)) else $error("pulse four");
  AST_ANALOG_AS_PORT: assert property (w6 && wsel == FN_ANALOG && wpull == PULL_OUTPUT |-> ##2
    !pad_analog[1] && pad_oe[1] && pad_out[1] == $past(port_out[1])) else $error("analog");
  AST_UNLISTED_PORT: assert property (w7 && wsel > FN_LAST && wpull == PULL_OUTPUT |-> ##2
    pad_oe[2] && pad_out[2] == $past(port_out[2])) else $error("unlisted code");
  AST_LOWER_WINS: assert property (ce && lower_claim[0] |=>
    serial_a_receive == $past(lower_value[0])) else $error("lower pin priority");
  AST_CLAIM_CHAIN: assert property (ce |=>
    (port0_claim & $past(lower_claim)) == $past(lower_claim)) else $error("claim chain");
  cover property (w6 && wsel == FN_DIAG);
  cover property (ce && reg_read ##1 reg_rdata != 16'h0000);
  cover property (ce && port0_claim != 11'h000);
endmodule

bind ppf_pin_function_select ppf_pin_function_select_checker chk_u (
  .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pad_out(pad_out),
  .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
  .pad_analog(pad_analog), .port_out(port_out), .serial_a_transmit(serial_a_transmit),
  .pulse_out_four(pulse_out_four), .radio_diagnostic_out(radio_diagnostic_out),
  .i2c_scl_drive_low(i2c_scl_drive_low), .serial_a_receive(serial_a_receive),
  .lower_claim(lower_claim), .lower_value(lower_value), .port0_claim(port0_claim)
);

// ---- tb/ppf_pad_model.sv ----
// Peripheral levels and pad behaviour around the pin function select block.
`timescale 1ns/10ps
module ppf_pad_model
  import ppf_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Pad side.
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  input wire logic [PIN_COUNT-1:0] pad_pull_up,
  input wire logic [PIN_COUNT-1:0] pad_pull_down,
  output logic [PIN_COUNT-1:0] pad_in,
  // Peripheral output levels.
  output logic [18:0] periph
);
  logic [21:0] lfsr_reg = 22'h2A5F3C;
  always_ff @(posedge clk) begin
    lfsr_reg <= {lfsr_reg[20:0], lfsr_reg[21] ^ lfsr_reg[20]};
  end
  assign periph = lfsr_reg[18:0];
  // A floating pad must not look stable, so it follows a changing pattern.
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (pad_pull_up[i] || pad_pull_down[i])
        pad_in[i] = pad_pull_up[i];
      else
        pad_in[i] = lfsr_reg[19 + i];
    end
  end
endmodule

// ---- tb/test_ppf_pin_function_select.sv ----
// Self-checking bench for the pin function select block.
`timescale 1ns/10ps
module test_ppf_pin_function_select import ppf_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [31:0] reg_addr = 32'h00000000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [2:0] port_out = 3'h0;
  logic [10:0] lower_claim = 11'h000;
  logic [10:0] lower_value = 11'h000;
  logic [10:0] port1_value = 11'h000;
  wire [15:0] reg_rdata;
  wire [2:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_analog, port_in;
  wire [10:0] iv, port0_claim;
  wire [18:0] pv;
  logic [15:0] exp_q [$];
  logic rd_d = 1'b0;
  logic [15:0] d;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  ppf_pin_function_select dut_u (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .pad_analog(pad_analog), .port_out(port_out),
    .port_in(port_in), .serial_a_transmit(pv[0]), .serial_b_transmit(pv[1]),
    .serial_a_infrared_transmit(pv[2]), .serial_b_infrared_transmit(pv[3]),
    .serial_a_request_to_send(pv[4]), .serial_b_request_to_send(pv[5]),
    .spi_data_out(pv[6]), .spi_clk_out(pv[7]), .spi_clk_oe(pv[8]), .spi_en_out(pv[9]),
    .spi_en_oe(pv[10]), .i2c_scl_drive_low(pv[11]), .i2c_sda_drive_low(pv[12]),
    .pulse_out_zero(pv[13]), .pulse_out_one(pv[14]), .pulse_out_two(pv[15]),
    .pulse_out_three(pv[16]), .pulse_out_four(pv[17]), .radio_diagnostic_out(pv[18]),
    .serial_a_receive(iv[0]), .serial_b_receive(iv[1]), .spi_data_in_sel(iv[2]),
    .spi_clk_in(iv[3]), .spi_en_in(iv[4]), .i2c_scl_in(iv[5]), .i2c_sda_in(iv[6]),
    .serial_a_infrared_receive(iv[7]), .serial_b_infrared_receive(iv[8]),
    .serial_a_clear_to_send(iv[9]), .serial_b_clear_to_send(iv[10]),
    .lower_claim(lower_claim), .lower_value(lower_value), .port1_value(port1_value),
    .port0_claim(port0_claim)
  );
  ppf_pad_model model_u (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .pad_in(pad_in), .periph(pv));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    port_out <= 3'($urandom);
    lower_claim <= 11'($urandom);
    lower_value <= 11'($urandom);
    port1_value <= 11'($urandom);
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) begin
    rd_d <= reg_read;
    cycles <= cycles + 1;
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    if (cycles == 4000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
  endtask

  task automatic idle();
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(posedge clk);
  endtask

  // Returns output enable and value expected on a pad for a selector code.
  function automatic logic [1:0] pad_exp(input logic [4:0] c, input logic [1:0] p,
      input logic po, input logic [18:0] v);
    case (c)
      FN_SA_TX: return {1'b1, v[0]};
      FN_SB_TX: return {1'b1, v[1]};
      FN_SA_IR_TX: return {1'b1, v[2]};
      FN_SB_IR_TX: return {1'b1, v[3]};
      FN_SA_RTS: return {1'b1, v[4]};
      FN_SB_RTS: return {1'b1, v[5]};
      FN_SPI_DO: return {1'b1, v[6]};
      FN_SPI_CLK: return {v[8], v[7]};
      FN_SPI_EN: return {v[10], v[9]};
      FN_I2C_SCL: return {v[11], 1'b0};
      FN_I2C_SDA: return {v[12], 1'b0};
      FN_PULSE0: return {1'b1, v[13]};
      FN_PULSE1: return {1'b1, v[14]};
      FN_PULSE2: return {1'b1, v[15]};
      FN_PULSE3: return {1'b1, v[16]};
      FN_PULSE4: return {1'b1, v[17]};
      FN_DIAG: return {1'b1, v[18]};
      FN_SA_RX, FN_SB_RX, FN_SPI_DIN, FN_SA_IR_RX, FN_SB_IR_RX, FN_SA_CTS, FN_SB_CTS: return 2'h0;
      default: return {p == PULL_OUTPUT, po};
    endcase
  endfunction

  task automatic pin_check(input int i, input logic [4:0] c, input logic [1:0] p);
    logic [1:0] e;
    logic [2:0] pi;
    @(posedge clk);
    e = pad_exp(c, p, port_out[i], pv);
    pi = pad_in;
    #1;
    chk(16'({pad_oe[i], pad_oe[i] & pad_out[i]}), 16'({e[1], e[1] & e[0]}));
    chk(16'({pad_pull_up[i], pad_pull_down[i], pad_analog[i]}), 16'({p == PULL_UP_IN, p == PULL_DOWN_IN, 1'b0}));
    chk(16'(port_in[i]), 16'(pi[i]));
    @(posedge clk);
  endtask

  task automatic in_check(input logic [10:0] m, input int b);
    logic [10:0] e;
    logic [10:0] lc;
    @(posedge clk);
    lc = lower_claim;
    e = (lc & lower_value) | (~lc & m & {11{pad_in[b]}}) | (~lc & ~m & port1_value);
    #1;
    chk(16'(iv), 16'(e));
    chk(16'(port0_claim), 16'(lc | m));
    @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'h49E1));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(16'(pad_pull_down), 16'h0007);
    for (int i = 0; i < PIN_COUNT; i++) begin
      rd(MODE_ADDR[i], 16'h0200);
    end
    wr(32'h50003016, 16'hFFFF);
    rd(32'h50003016, 16'h0000);
    rd(PIN7_MODE_SELECT_ADDR, 16'h0200);
    idle();
    // A write while the enable is low must leave the register untouched.
    ce <= 1'b0;
    wr(PIN5_MODE_SELECT_ADDR, 16'h0312);
    ce <= 1'b1;
    rd(PIN5_MODE_SELECT_ADDR, 16'h0200);
    idle();
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < CODE_COUNT; c++) begin
        for (int i = 0; i < PIN_COUNT; i++) begin
          d = 16'($urandom);
          d[9:8] = 2'(p);
          d[4:0] = 5'(c);
          wr(MODE_ADDR[i], d);
          rd(MODE_ADDR[i], d & 16'h031F);
          idle();
          pin_check(i, 5'(c), 2'(p));
        end
      end
    end
    for (int k = 0; k < IN_COUNT; k++) begin
      wr(PIN5_MODE_SELECT_ADDR, 16'h0000);
      wr(PIN6_MODE_SELECT_ADDR, {11'h000, IN_CODE[k]});
      wr(PIN7_MODE_SELECT_ADDR, {11'h000, IN_CODE[k]});
      idle();
      in_check(11'(1 << k), 1);
      wr(PIN5_MODE_SELECT_ADDR, {11'h000, IN_CODE[k]});
      idle();
      in_check(11'(1 << k), 0);
    end
    tally_and_finish();
  end
endmodule
